// file: verilog/dpr_top.sv
// axi4-lite slave over the read-only discoverable parameter space
// assumes one clock, synchronous inputs, and a master that keeps
// valid and payload stable until each handshake
//
// What this block does
// - serves mandatory header FF00h and its basic table
// - bytes 00h-03h return signature 53h 46h 44h 50h
// - revision 1.6, header count zero, byte 07h FFh
// - header id 00h, revision 1.6, length 10h
// - table location 000030h, id high byte FFh
// - 4 KB erase, write granularity, nonvolatile protection
// - byte 30h upper bits, erase code 20h
// - fast-read variants, double rate, three-byte addressing
// - byte 33h FFh, density 03FFFFFFh
// - quad-io read timing 4 wait, 2 mode, EBh
// - quad-output read timing 8 wait, 6Bh
// - dual-output read timing 8 wait, 3Bh
// - dual-io read timing 0 wait, 4 mode, BBh
module dpr_top
  import dpr_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  // word-aligned offsets inside the constant store
  function automatic logic is_rom(logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_ROM_LAST);
  endfunction

  // one byte lane out of a word
  function automatic logic [7:0] lane_of(logic [DATA_W-1:0] w,
                                         logic [1:0]        l);
    return w[8*l +: 8];
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  dpr_rd_state_t     rd_state_r, rd_state_nxt;
  dpr_wr_state_t     wr_state_r, wr_state_nxt;
  logic [ADDR_W-1:0] ar_addr_r, ar_addr_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [3:0]        wstrb_r, wstrb_nxt;
  logic              aw_got_r, aw_got_nxt;
  logic              w_got_r, w_got_nxt;
  logic [PTR_W-1:0]  byte_ptr_r, byte_ptr_nxt;
  logic [PTR_W-1:0]  lane_ptr_r, lane_ptr_nxt;
  logic              arready_r, arready_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic              awready_r, awready_nxt;
  logic              wready_r, wready_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic              bvalid_r, bvalid_nxt;

  logic              rom_en;
  logic [ROM_AW-1:0] rom_idx;
  logic [DATA_W-1:0] rom_q;

  // ************************************************************
  // constant store
  // ************************************************************
  dpr_rom u_rom (
    .aclk (aclk),
    .en   (rom_en),
    .idx  (rom_idx),
    .q    (rom_q)
  );

  // the store is only ever read; nothing on the write side reaches it
  always_comb begin
    rom_en  = ce && (rd_state_r == RD_FETCH);
    rom_idx = ar_addr_r[5:2];
    if (ar_addr_r == OFS_BYTE_DATA) begin
      rom_idx = byte_ptr_r[5:2];
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  always_comb begin
    rd_state_nxt = rd_state_r;
    ar_addr_nxt  = ar_addr_r;
    arready_nxt  = arready_r;
    rdata_nxt    = rdata_r;
    rresp_nxt    = rresp_r;
    rvalid_nxt   = rvalid_r;
    lane_ptr_nxt = lane_ptr_r;
    case (rd_state_r)
      RD_IDLE: begin
        if (s_axi_arvalid && arready_r) begin
          ar_addr_nxt  = s_axi_araddr;
          arready_nxt  = 1'b0;
          rd_state_nxt = RD_FETCH;
        end
      end
      RD_FETCH: begin
        // keep the address the lane pick will use
        lane_ptr_nxt = byte_ptr_r;
        rd_state_nxt = RD_LOAD;
      end
      RD_LOAD: begin
        rresp_nxt  = RESP_OKAY;
        rvalid_nxt = 1'b1;
        if (is_rom(ar_addr_r)) begin
          rdata_nxt = rom_q;
        end else if (ar_addr_r == OFS_BYTE_PTR) begin
          rdata_nxt = {{(DATA_W-PTR_W){1'b0}}, byte_ptr_r};
        end else if (ar_addr_r == OFS_BYTE_DATA) begin
          rdata_nxt = {24'h000000, VAL_BYTE_ERASED};
          if (lane_ptr_r < PARAM_SPACE_END) begin
            rdata_nxt = {24'h000000,
                         lane_of(rom_q, lane_ptr_r[1:0])};
          end
        end else begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = RESP_SLVERR;
        end
        rd_state_nxt = RD_RESP;
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          rvalid_nxt   = 1'b0;
          arready_nxt  = 1'b1;
          rd_state_nxt = RD_IDLE;
        end
      end
      default: begin
        rvalid_nxt   = 1'b0;
        arready_nxt  = 1'b1;
        rd_state_nxt = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= RD_IDLE;
      ar_addr_r  <= 8'h00;
      arready_r  <= 1'b1;
      rdata_r    <= 32'h00000000;
      rresp_r    <= RESP_OKAY;
      rvalid_r   <= 1'b0;
      lane_ptr_r <= RST_BYTE_PTR;
    end else if (ce) begin
      rd_state_r <= rd_state_nxt;
      ar_addr_r  <= ar_addr_nxt;
      arready_r  <= arready_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
      rvalid_r   <= rvalid_nxt;
      lane_ptr_r <= lane_ptr_nxt;
    end
  end

  // ************************************************************
  // write channel
  // ************************************************************
  always_comb begin
    wr_state_nxt = wr_state_r;
    aw_addr_nxt  = aw_addr_r;
    wdata_nxt    = wdata_r;
    wstrb_nxt    = wstrb_r;
    aw_got_nxt   = aw_got_r;
    w_got_nxt    = w_got_r;
    awready_nxt  = awready_r;
    wready_nxt   = wready_r;
    bresp_nxt    = bresp_r;
    bvalid_nxt   = bvalid_r;
    case (wr_state_r)
      WR_IDLE: begin
        // address and data are taken in either order
        if (s_axi_awvalid && awready_r) begin
          aw_addr_nxt = s_axi_awaddr;
          aw_got_nxt  = 1'b1;
          awready_nxt = 1'b0;
        end
        if (s_axi_wvalid && wready_r) begin
          wdata_nxt  = s_axi_wdata;
          wstrb_nxt  = s_axi_wstrb;
          w_got_nxt  = 1'b1;
          wready_nxt = 1'b0;
        end
        if (aw_got_nxt && w_got_nxt) begin
          wr_state_nxt = WR_COLL;
        end
      end
      WR_COLL: begin
        // only the byte pointer is writable; the store answers error
        bresp_nxt = (aw_addr_r == OFS_BYTE_PTR) ? RESP_OKAY
                                                : RESP_SLVERR;
        bvalid_nxt   = 1'b1;
        wr_state_nxt = WR_RESP;
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_nxt   = 1'b0;
          aw_got_nxt   = 1'b0;
          w_got_nxt    = 1'b0;
          awready_nxt  = 1'b1;
          wready_nxt   = 1'b1;
          wr_state_nxt = WR_IDLE;
        end
      end
      default: begin
        bvalid_nxt   = 1'b0;
        aw_got_nxt   = 1'b0;
        w_got_nxt    = 1'b0;
        awready_nxt  = 1'b1;
        wready_nxt   = 1'b1;
        wr_state_nxt = WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_r <= WR_IDLE;
      aw_addr_r  <= 8'h00;
      wdata_r    <= 32'h00000000;
      wstrb_r    <= 4'h0;
      aw_got_r   <= 1'b0;
      w_got_r    <= 1'b0;
      awready_r  <= 1'b1;
      wready_r   <= 1'b1;
      bresp_r    <= RESP_OKAY;
      bvalid_r   <= 1'b0;
    end else if (ce) begin
      wr_state_r <= wr_state_nxt;
      aw_addr_r  <= aw_addr_nxt;
      wdata_r    <= wdata_nxt;
      wstrb_r    <= wstrb_nxt;
      aw_got_r   <= aw_got_nxt;
      w_got_r    <= w_got_nxt;
      awready_r  <= awready_nxt;
      wready_r   <= wready_nxt;
      bresp_r    <= bresp_nxt;
      bvalid_r   <= bvalid_nxt;
    end
  end

  // ************************************************************
  // byte pointer
  // ************************************************************
  // a write sets the start address; each stream read steps it by one.
  // the two channels run independently, so both may meet in one cycle:
  // the write is applied last and wins in each byte its strobe enables.
  always_comb begin
    byte_ptr_nxt = byte_ptr_r;
    if (rd_state_r == RD_FETCH && ar_addr_r == OFS_BYTE_DATA) begin
      byte_ptr_nxt = byte_ptr_r + 24'h000001;
    end
    if (wr_state_r == WR_COLL && aw_addr_r == OFS_BYTE_PTR) begin
      for (int i = 0; i < PTR_W / 8; i++) begin
        if (wstrb_r[i]) begin
          byte_ptr_nxt[8*i +: 8] = wdata_r[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_ptr_r <= RST_BYTE_PTR;
    end else if (ce) begin
      byte_ptr_r <= byte_ptr_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign s_axi_arready = arready_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_bvalid  = bvalid_r;

endmodule

// file: common/dpr_pkg.sv
// constants of the discoverable parameter store and its register map
// assumes a 32-bit axi4-lite bus with byte addresses on 8 bits
package dpr_pkg;

  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned PTR_W       = 24;
  localparam int unsigned ROM_DEPTH   = 16;
  localparam int unsigned ROM_AW      = 4;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_SIGNATURE   = 8'h00;
  localparam logic [7:0] OFS_REVISION    = 8'h04;
  localparam logic [7:0] OFS_HDR_ID      = 8'h08;
  localparam logic [7:0] OFS_HDR_LOC     = 8'h0C;
  localparam logic [7:0] OFS_ERASE_READ  = 8'h30;
  localparam logic [7:0] OFS_DENSITY     = 8'h34;
  localparam logic [7:0] OFS_QUAD_TIMING = 8'h38;
  localparam logic [7:0] OFS_DUAL_TIMING = 8'h3C;
  localparam logic [7:0] OFS_ROM_LAST    = 8'h3C;
  localparam logic [7:0] OFS_BYTE_PTR    = 8'h40;
  localparam logic [7:0] OFS_BYTE_DATA   = 8'h44;

  // ************************************************************
  // parameter space contents, lowest byte first in each word
  // ************************************************************
  localparam logic [31:0] VAL_SIGNATURE   = 32'h50444653;
  localparam logic [31:0] VAL_REVISION    = 32'hFF000106;
  localparam logic [31:0] VAL_HDR_ID      = 32'h10010600;
  localparam logic [31:0] VAL_HDR_LOC     = 32'hFF000030;
  localparam logic [31:0] VAL_ERASE_READ  = 32'hFFF920E5;
  localparam logic [31:0] VAL_DENSITY     = 32'h03FFFFFF;
  localparam logic [31:0] VAL_QUAD_TIMING = 32'h6B08EB44;
  localparam logic [31:0] VAL_DUAL_TIMING = 32'hBB803B08;
  localparam logic [31:0] VAL_ERASED      = 32'hFFFFFFFF;
  localparam logic [7:0]  VAL_BYTE_ERASED = 8'hFF;
  localparam logic [23:0] PARAM_SPACE_END = 24'h000040;

  // ************************************************************
  // reset values and answers
  // ************************************************************
  localparam logic [PTR_W-1:0] RST_BYTE_PTR = 24'h000000;
  localparam logic [1:0]       RESP_OKAY    = 2'h0;
  localparam logic [1:0]       RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    RD_IDLE  = 2'b00,
    RD_FETCH = 2'b01,
    RD_LOAD  = 2'b10,
    RD_RESP  = 2'b11
  } dpr_rd_state_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_COLL = 2'b01,
    WR_RESP = 2'b10
  } dpr_wr_state_t;

endpackage

// file: verilog/dpr_rom.sv
// sixteen-word constant store with a registered read port
// assumes the caller holds the word index while en is high
module dpr_rom
  import dpr_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              en,
  input  wire logic [ROM_AW-1:0] idx,
  output logic      [DATA_W-1:0] q
);

  // ************************************************************
  // contents
  // ************************************************************
  function automatic logic [DATA_W-1:0] word_at(logic [ROM_AW-1:0] i);
    logic [DATA_W-1:0] w;
    w = VAL_ERASED;
    case ({i, 2'b00})
      OFS_SIGNATURE[5:0]:   w = VAL_SIGNATURE;
      OFS_REVISION[5:0]:    w = VAL_REVISION;
      OFS_HDR_ID[5:0]:      w = VAL_HDR_ID;
      OFS_HDR_LOC[5:0]:     w = VAL_HDR_LOC;
      OFS_ERASE_READ[5:0]:  w = VAL_ERASE_READ;
      OFS_DENSITY[5:0]:     w = VAL_DENSITY;
      OFS_QUAD_TIMING[5:0]: w = VAL_QUAD_TIMING;
      OFS_DUAL_TIMING[5:0]: w = VAL_DUAL_TIMING;
      default:              w = VAL_ERASED;
    endcase
    return w;
  endfunction

  // ************************************************************
  // read register
  // ************************************************************
  logic [DATA_W-1:0] q_nxt;

  always_comb begin
    q_nxt = q;
    if (en) begin
      q_nxt = word_at(idx);
    end
  end

  always_ff @(posedge aclk) begin
    q <= q_nxt;
  end

endmodule

// file: testbench/dpr_top_monitor.sv
// checker for the axi4-lite face of the parameter store
// assumes ce stays high while checks are meant to run
module dpr_top_monitor
  import dpr_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // addresses of the transfers in flight
  // ************************************************************
  logic [ADDR_W-1:0] ra_r;
  logic [ADDR_W-1:0] wa_r;
  logic              rd_hs;
  assign rd_hs = s_axi_rvalid && s_axi_rready;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
    if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
  end
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  property p_sig;
    rd_hs && ra_r == 8'h00 |-> s_axi_rdata == 32'h50444653;
  endproperty
  a_sig: assert property (p_sig) else $error("bad signature");
  property p_rev;
    rd_hs && ra_r == 8'h04 |-> s_axi_rdata == 32'hFF000106;
  endproperty
  a_rev: assert property (p_rev) else $error("bad revision");
  property p_hdr;
    rd_hs && ra_r == 8'h08 |-> s_axi_rdata == 32'h10010600;
  endproperty
  a_hdr: assert property (p_hdr) else $error("bad header id");
  property p_loc;
    rd_hs && ra_r == 8'h0C |-> s_axi_rdata == 32'hFF000030;
  endproperty
  a_loc: assert property (p_loc) else $error("bad location");
  property p_erase;
    rd_hs && ra_r == 8'h30 |-> s_axi_rdata == 32'hFFF920E5;
  endproperty
  a_erase: assert property (p_erase) else $error("bad erase");
  property p_dens;
    rd_hs && ra_r == 8'h34 |-> s_axi_rdata == 32'h03FFFFFF;
  endproperty
  a_dens: assert property (p_dens) else $error("bad density");
  property p_quad;
    rd_hs && ra_r == 8'h38 |-> s_axi_rdata == 32'h6B08EB44;
  endproperty
  a_quad: assert property (p_quad) else $error("bad quad");
  property p_dual;
    rd_hs && ra_r == 8'h3C |-> s_axi_rdata == 32'hBB803B08;
  endproperty
  a_dual: assert property (p_dual) else $error("bad dual");
  property p_wr;
    s_axi_bvalid && s_axi_bready && wa_r != 8'h40 |->
      s_axi_bresp == RESP_SLVERR;
  endproperty
  a_wr: assert property (p_wr) else $error("store write taken");
  property p_strm;
    rd_hs && ra_r == 8'h44 |->
      s_axi_rdata[31:8] == 24'h000000 && s_axi_rresp == RESP_OKAY;
  endproperty
  a_strm: assert property (p_strm) else $error("bad stream byte");
endmodule
bind dpr_top dpr_top_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

// file: testbench/dpr_host_model.sv
// axi4-lite host that reads and writes the parameter store
// assumes the bench calls one task at a time from one process
module dpr_host_model
  import dpr_pkg::*;
(
  input  wire logic              aclk,
  output logic      [ADDR_W-1:0] s_axi_awaddr,
  output logic                   s_axi_awvalid,
  input  wire logic              s_axi_awready,
  output logic      [DATA_W-1:0] s_axi_wdata,
  output logic      [3:0]        s_axi_wstrb,
  output logic                   s_axi_wvalid,
  input  wire logic              s_axi_wready,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_bvalid,
  output logic                   s_axi_bready,
  output logic      [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_arvalid,
  input  wire logic              s_axi_arready,
  input  wire logic [DATA_W-1:0] s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp,
  input  wire logic              s_axi_rvalid,
  output logic                   s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr} = 16'h0000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
  end
  // released payloads are inverted so stale values cannot match
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// file: testbench/dpr_top_tb.sv
// self-checking bench for the parameter store
// assumes the host model and the bound checker beside the design
module dpr_top_tb
  import dpr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          miscompares = 0;
  int          checks_done = 0;
  logic [31:0] exp_w [16];
  always #2.5 aclk = ~aclk;
  dpr_top DUT (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  dpr_host_model u_host (
    .aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ************************************************************
  // compares and closing
  // ************************************************************
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp,
                          input string msg);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp,
                          input string msg);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_b(input logic [7:0] a);
    return (a < 8'h40) ? 8'(exp_w[a[5:2]] >> {a[1:0], 3'b000}) : 8'hFF;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #50us;
    miscompares++;
    test_done();
  end
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  starts [2];
    logic [7:0]  bad [2];
    starts = '{8'h3E, 8'h00};
    bad = '{8'h48, 8'h02};
    exp_w = '{0: 32'h50444653, 1: 32'hFF000106, 2: 32'h10010600,
              3: 32'hFF000030, 12: 32'hFFF920E5, 13: 32'h03FFFFFF,
              14: 32'h6B08EB44, 15: 32'hBB803B08, default: 32'hFFFFFFFF};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      u_host.rd(8'(i * 4), d, r);
      if (i < 12) chk_data(d, exp_w[i], "header");
      else chk_data(d, exp_w[i], "table");
      chk_resp(r, RESP_OKAY, "word resp");
    end
    $display("test word map done");
    u_host.wr(8'h30, 32'h00000000, r);
    chk_resp(r, RESP_SLVERR, "store write");
    u_host.wr(8'h00, 32'h12345678, r);
    chk_resp(r, RESP_SLVERR, "store write");
    u_host.rd(8'h30, d, r);
    chk_data(d, exp_w[12], "after write");
    u_host.rd(8'h00, d, r);
    chk_data(d, exp_w[0], "after write");
    $display("test constant store done");
    foreach (starts[j]) begin
      u_host.wr(8'h40, {24'h000000, starts[j]}, r);
      chk_resp(r, RESP_OKAY, "pointer write");
      for (int k = 0; k < 4; k++) begin
        u_host.rd(8'h44, d, r);
        chk_data(d, 32'(exp_b(8'(starts[j] + k))), "byte");
      end
      u_host.rd(8'h40, d, r);
      chk_data(d, {24'h000000, starts[j]} + 32'h4, "pointer");
    end
    $display("test byte stream done");
    // a reset in mid-run must bring the pointer back from 04h
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    u_host.rd(8'h40, d, r);
    chk_data(d, {8'h00, RST_BYTE_PTR}, "pointer after reset");
    $display("test reset done");
    // freeze in mid-read: the pointer must step only once
    u_host.wr(8'h40, 32'h00000005, r);
    chk_resp(r, RESP_OKAY, "pointer write");
    fork
      u_host.rd(8'h44, d, r);
      begin
        do @(posedge aclk); while (!(arvalid && arready));
        ce <= 1'b0;
        repeat (3) @(posedge aclk);
        ce <= 1'b1;
      end
    join
    chk_data(d, 32'(exp_b(8'h05)), "frozen byte");
    chk_resp(r, RESP_OKAY, "frozen resp");
    u_host.rd(8'h40, d, r);
    chk_data(d, 32'h00000006, "frozen pointer");
    $display("test clock enable done");
    foreach (bad[j]) begin
      u_host.rd(bad[j], d, r);
      chk_resp(r, RESP_SLVERR, "unmapped resp");
      chk_data(d, 32'h00000000, "unmapped data");
    end
    $display("test unmapped done");
    test_done();
  end
endmodule
